// [hw/bit_ops_io_datapath.sv]
// execution datapath for branches, shifts, flag and io bit operations
// assumes io bus read data is valid in the cycle the read strobe is high
//
// Notes on behaviour
// - overflow-clear branch, one or two cycles
// - irq-on/off branches jump on global flag
// - io bit set/clear, two cycles, flags kept
// - bit set/clear only io 0x00..0x1F
// - bit set/clear rewrites whole register
// - some flags cleared by writing one
// - skip tests reach io bits up to 0x1F
// - io ops use 0..0x3F, data +0x20
// - extended region only via data loads/stores
// - left shift, zero in, flags, one cycle
// - right shift, zero in, flags, one cycle
// - arithmetic right shift keeps bit 7
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - selected bit copied into transfer flag
// - transfer flag into bit, flags kept
`timescale 1ns/1ps
module bit_ops_io_datapath (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_nrst,
  input  wire logic                          i_op_valid,
  input  wire bitops_pkg::op_type            i_op_code,
  input  wire logic [bitops_pkg::DW-1:0]     i_opnd,
  input  wire logic [2:0]                    i_bit_sel,
  input  wire logic [bitops_pkg::IAW-1:0]    i_io_addr,
  input  wire logic [bitops_pkg::DAW-1:0]    i_data_addr,
  input  wire logic [bitops_pkg::OFW-1:0]    i_offset,
  input  wire logic [bitops_pkg::PCW-1:0]    i_pc,
  output logic                               o_busy,
  output logic                               o_done,
  output logic [bitops_pkg::DW-1:0]          o_result,
  output logic                               o_result_we,
  output logic [bitops_pkg::PCW-1:0]         o_pc_next,
  output logic                               o_skip,
  output logic                               o_bad_addr,
  output logic [bitops_pkg::DW-1:0]          o_stat,
  output logic [bitops_pkg::DAW-1:0]         o_io_addr,
  output logic [bitops_pkg::DW-1:0]          o_io_wdata,
  output logic                               o_io_we,
  output logic                               o_io_re,
  input  wire logic [bitops_pkg::DW-1:0]     i_io_rdata,
  input  wire logic [1:0]                    i_reg_addr,
  input  wire logic [bitops_pkg::DW-1:0]     i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic [bitops_pkg::DW-1:0]          o_reg_rdata
);
  import bitops_pkg::*;

  // ==========================================================
  // decode helpers
  function automatic logic is_bit_rmw(input op_type op);
    return (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLR);
  endfunction

  function automatic logic is_skip(input op_type op);
    return (op == OP_SKIP_ONE) || (op == OP_SKIP_ZERO);
  endfunction

  function automatic logic is_io_op(input op_type op);
    return is_bit_rmw(op) || is_skip(op) || (op == OP_IO_IN) ||
           (op == OP_IO_OUT) || (op == OP_DS_LOAD) || (op == OP_DS_STORE);
  endfunction

  function automatic logic is_branch(input op_type op);
    return (op == OP_BR_OVF_CLR) || (op == OP_BR_IRQ_ON) ||
           (op == OP_BR_IRQ_OFF);
  endfunction

  // ==========================================================
  // state and working registers
  state_type            state_ff;
  state_type            nxt_state;
  op_type               op_ff;
  logic [2:0]           bit_ff;
  logic [DW-1:0]        stat_ff;
  logic [DW-1:0]        nxt_stat;
  logic [DW-1:0]        nxt_res;
  logic                 nxt_res_we;
  logic                 take;
  logic                 accept;
  logic [PCW-1:0]       tgt_pc;
  logic [DW-1:0]        bit_mask;
  logic [DW-1:0]        rmw_mask;
  logic [DW-1:0]        rmw_data;
  logic                 io_ok;
  io_map_if             map_if ();

  assign accept   = i_op_valid && (state_ff == SM_IDLE);
  assign bit_mask = DW'(1) << i_bit_sel;
  assign rmw_mask = DW'(1) << bit_ff;
  assign tgt_pc   = i_pc + PCW'($signed(i_offset)) + PC_STEP;

  // ==========================================================
  // address mapping
  assign map_if.use_io    = (i_op_code != OP_DS_LOAD) &&
                            (i_op_code != OP_DS_STORE);
  assign map_if.io_addr   = i_io_addr;
  assign map_if.data_addr = i_data_addr;

  io_addr_map u_map (
    .m (map_if)
  );

  // bit ops and skips need the low block, the rest any mapped address
  always_comb begin
    if (is_bit_rmw(i_op_code) || is_skip(i_op_code)) begin
      io_ok = map_if.bit_ok;
    end else begin
      io_ok = map_if.in_range;
    end
  end

  // ==========================================================
  // branch condition
  always_comb begin
    case (i_op_code)
      OP_BR_OVF_CLR: take = !stat_ff[SB_V];
      OP_BR_IRQ_ON:  take = stat_ff[SB_I];
      OP_BR_IRQ_OFF: take = !stat_ff[SB_I];
      default:       take = 1'b0;
    endcase
  end

  // ==========================================================
  // single-cycle register and flag results
  always_comb begin
    nxt_stat   = stat_ff;
    nxt_res    = i_opnd;
    case (i_op_code)
      OP_SHL: begin
        nxt_res        = {i_opnd[MSB-1:0], 1'b0};
        nxt_stat[SB_C] = i_opnd[MSB];
      end
      OP_SHR: begin
        nxt_res        = {1'b0, i_opnd[MSB:1]};
        nxt_stat[SB_C] = i_opnd[0];
      end
      OP_SAR: begin
        nxt_res        = {i_opnd[MSB], i_opnd[MSB:1]};
        nxt_stat[SB_C] = i_opnd[0];
      end
      OP_RCL: begin
        nxt_res        = {i_opnd[MSB-1:0], stat_ff[SB_C]};
        nxt_stat[SB_C] = i_opnd[MSB];
      end
      OP_RCR: begin
        nxt_res        = {stat_ff[SB_C], i_opnd[MSB:1]};
        nxt_stat[SB_C] = i_opnd[0];
      end
      OP_SWAP:     nxt_res = {i_opnd[3:0], i_opnd[MSB:4]};
      OP_FLAG_SET: nxt_stat = stat_ff | bit_mask;
      OP_FLAG_CLR: nxt_stat = stat_ff & ~bit_mask;
      OP_BIT_TO_T: nxt_stat[SB_T] = i_opnd[i_bit_sel];
      OP_T_TO_BIT: nxt_res = (i_opnd & ~bit_mask) | (stat_ff[SB_T] ? bit_mask : DW'(0));
      default:     nxt_res = i_opnd;
    endcase
    // ops that hand back a register result
    nxt_res_we = (i_op_code inside {OP_SHL, OP_SHR, OP_SAR, OP_RCL, OP_RCR, OP_SWAP,
                                    OP_T_TO_BIT});
    // shared flag update for the shift and rotate forms
    if (i_op_code inside {OP_SHL, OP_SHR, OP_SAR, OP_RCL, OP_RCR}) begin
      nxt_stat[SB_Z] = (nxt_res == DW'(0));
      nxt_stat[SB_N] = nxt_res[MSB];
      nxt_stat[SB_V] = nxt_res[MSB] ^ nxt_stat[SB_C];
    end
  end

  // whole-register write-back; flags read as one go back as one
  assign rmw_data = (op_ff == OP_IO_BIT_SET) ? (i_io_rdata | rmw_mask)
                                             : (i_io_rdata & ~rmw_mask);

  // ==========================================================
  // sequencing state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SM_IDLE: begin
        if (accept && is_branch(i_op_code) && take) begin
          nxt_state = SM_BR2;
        end else if (accept && is_io_op(i_op_code) && io_ok) begin
          nxt_state = SM_IO;
        end
      end
      SM_BR2, SM_IO, SM_WB: nxt_state = SM_IDLE;
      default: nxt_state = SM_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_ff <= SM_IDLE;
      o_busy   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_busy   <= (nxt_state != SM_IDLE);
    end
  end

  // latched operation for the second cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      op_ff  <= OP_NOP;
      bit_ff <= 3'h0;
    end else if (accept) begin
      op_ff  <= i_op_code;
      bit_ff <= i_bit_sel;
    end
  end

  // ==========================================================
  // status register; datapath update beats a software write
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      stat_ff <= STAT_RST;
    end else if (accept) begin
      stat_ff <= nxt_stat;
    end else if (i_reg_wr && (i_reg_addr == REG_STATUS)) begin
      stat_ff <= i_reg_wdata;
    end
  end

  assign o_stat = stat_ff;

  // ==========================================================
  // completion, result and program counter
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_done      <= 1'b0;
      o_result    <= 8'h00;
      o_result_we <= 1'b0;
      o_skip      <= 1'b0;
      o_bad_addr  <= 1'b0;
      o_pc_next   <= 16'h0000;
    end else begin
      o_done      <= 1'b0;
      o_result_we <= 1'b0;
      o_skip      <= 1'b0;
      o_bad_addr  <= 1'b0;
      if (accept) begin
        o_pc_next <= take ? tgt_pc : (i_pc + PC_STEP);
        if (is_io_op(i_op_code) && !io_ok) begin
          o_done     <= 1'b1; // no bus access
          o_bad_addr <= 1'b1;
        end else if (!(is_branch(i_op_code) && take) &&
                     !is_io_op(i_op_code)) begin
          o_done      <= 1'b1;
          o_result    <= nxt_res;
          o_result_we <= nxt_res_we;
        end
      end else if (state_ff == SM_BR2) begin
        o_done <= 1'b1; // taken path, second cycle
      end else if (state_ff == SM_IO) begin
        o_done <= 1'b1;
        if ((op_ff == OP_IO_IN) || (op_ff == OP_DS_LOAD)) begin
          o_result    <= i_io_rdata;
          o_result_we <= 1'b1;
        end
        if (op_ff == OP_SKIP_ONE) begin
          o_skip <= i_io_rdata[bit_ff];
        end else if (op_ff == OP_SKIP_ZERO) begin
          o_skip <= !i_io_rdata[bit_ff];
        end
      end
    end
  end

  // ==========================================================
  // internal io bus strobes
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_io_addr  <= 9'h000;
      o_io_wdata <= 8'h00;
      o_io_we    <= 1'b0;
      o_io_re    <= 1'b0;
    end else begin
      o_io_we <= 1'b0;
      o_io_re <= 1'b0;
      if (accept && is_io_op(i_op_code) && io_ok) begin
        o_io_addr  <= map_if.bus_addr;
        o_io_wdata <= i_opnd;
        if ((i_op_code == OP_IO_OUT) || (i_op_code == OP_DS_STORE)) begin
          o_io_we <= 1'b1;
        end else begin
          o_io_re <= 1'b1; // read half
        end
      end else if ((state_ff == SM_IO) && is_bit_rmw(op_ff)) begin
        o_io_wdata <= rmw_data; // write half
        o_io_we    <= 1'b1;
      end
    end
  end

  // ==========================================================
  // software read port, data for one cycle only
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_STATUS: o_reg_rdata <= stat_ff;
        REG_RESULT: o_reg_rdata <= o_result;
        REG_PC_LO:  o_reg_rdata <= o_pc_next[DW-1:0];
        REG_PC_HI:  o_reg_rdata <= o_pc_next[PCW-1:DW];
        default:    o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  sequence s_rmw_steps;
    o_io_re ##1 (o_io_we && o_done);
  endsequence

  property p_br_ovf;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && (i_op_code == OP_BR_OVF_CLR) && !stat_ff[SB_V] |=>
      !o_done ##1 (o_done && (o_pc_next == $past(tgt_pc, 2)));
  endproperty
  a_br_ovf: assert property (p_br_ovf) else $error("taken branch bad");

  property p_br_irq_off_nt;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && (i_op_code == OP_BR_IRQ_OFF) && stat_ff[SB_I] |=>
      o_done && (o_pc_next == $past(i_pc) + PC_STEP);
  endproperty
  a_br_irq_off_nt: assert property (p_br_irq_off_nt)
    else $error("untaken branch bad");

  property p_rmw;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && is_bit_rmw(i_op_code) && map_if.bit_ok |=>
      s_rmw_steps ##0 (o_stat == $past(stat_ff, 2));
  endproperty
  a_rmw: assert property (p_rmw) else $error("bit rmw sequence bad");

  property p_bit_range;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && is_bit_rmw(i_op_code) && (i_io_addr > IO_BIT_MAX) |=>
      o_bad_addr && !o_io_re && !o_io_we;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("high io bit op");

  property p_rmw_keep;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (state_ff == SM_IO) && is_bit_rmw(op_ff) |=>
      ((o_io_wdata | $past(rmw_mask)) == ($past(i_io_rdata) | $past(rmw_mask)));
  endproperty
  a_rmw_keep: assert property (p_rmw_keep) else $error("rmw lost bits");

  property p_io_ofs;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && (i_op_code == OP_IO_IN) |=>
      o_io_re && (o_io_addr == DAW'({3'h0, $past(i_io_addr)}) + IO_DS_OFS);
  endproperty
  a_io_ofs: assert property (p_io_ofs) else $error("io offset bad");

  property p_left_shift;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && (i_op_code == OP_SHL) |=>
      (o_result == {$past(i_opnd[MSB-1:0]), 1'b0}) &&
      (o_stat[SB_C] == $past(i_opnd[MSB])) && o_done;
  endproperty
  a_left_shift: assert property (p_left_shift) else $error("left shift bad");

  property p_swap;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && (i_op_code == OP_SWAP) |=>
      (o_result == {$past(i_opnd[3:0]), $past(i_opnd[MSB:4])}) &&
      (o_stat == $past(stat_ff));
  endproperty
  a_swap: assert property (p_swap) else $error("swap bad");

  property p_t_to_bit;
    @(posedge i_core_clk) disable iff (!i_nrst)
    accept && (i_op_code == OP_T_TO_BIT) |=>
      (o_result[$past(i_bit_sel)] == $past(stat_ff[SB_T])) &&
      (o_stat == $past(stat_ff));
  endproperty
  a_t_to_bit: assert property (p_t_to_bit) else $error("t load bad");
endmodule

// [hw/bitops_pkg.sv]
// constants, opcodes and status bit layout for the bit/io datapath
// assumes an 8-bit core with a 9-bit data space and a 6-bit io space
package bitops_pkg;
  // ==========================================================
  // widths
  localparam int unsigned DW  = 8;
  localparam int unsigned PCW = 16;
  localparam int unsigned DAW = 9;
  localparam int unsigned IAW = 6;
  localparam int unsigned OFW = 7;

  // ==========================================================
  // status register bit positions
  localparam int unsigned SB_C = 0;
  localparam int unsigned SB_Z = 1;
  localparam int unsigned SB_N = 2;
  localparam int unsigned SB_V = 3;
  localparam int unsigned SB_S = 4;
  localparam int unsigned SB_H = 5;
  localparam int unsigned SB_T = 6;
  localparam int unsigned SB_I = 7;
  localparam int unsigned MSB  = DW - 1;
  localparam logic [DW-1:0] STAT_RST = 8'h00;

  // ==========================================================
  // address map of the io space
  localparam logic [DAW-1:0] IO_DS_OFS  = 9'h020;
  localparam logic [IAW-1:0] IO_BIT_MAX = 6'h1F;
  localparam logic [DAW-1:0] DS_IO_MIN  = 9'h020;

  // ==========================================================
  // software register port offsets
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_RESULT = 2'h1;
  localparam logic [1:0] REG_PC_LO  = 2'h2;
  localparam logic [1:0] REG_PC_HI  = 2'h3;
  localparam logic [PCW-1:0] PC_STEP = 16'h0001;

  // ==========================================================
  // operations handled by this slice
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BR_OVF_CLR = 5'h01, OP_BR_IRQ_ON = 5'h02,
    OP_BR_IRQ_OFF = 5'h03, OP_IO_BIT_SET = 5'h04, OP_IO_BIT_CLR = 5'h05,
    OP_SKIP_ONE = 5'h06, OP_SKIP_ZERO = 5'h07, OP_SHL = 5'h08,
    OP_SHR = 5'h09, OP_RCL = 5'h0A, OP_RCR = 5'h0B, OP_SAR = 5'h0C,
    OP_SWAP = 5'h0D, OP_FLAG_SET = 5'h0E, OP_FLAG_CLR = 5'h0F,
    OP_BIT_TO_T = 5'h10, OP_T_TO_BIT = 5'h11, OP_IO_IN = 5'h12,
    OP_IO_OUT = 5'h13, OP_DS_LOAD = 5'h14, OP_DS_STORE = 5'h15
  } op_type;

  typedef enum logic [3:0] {
    SM_IDLE = 4'b0001,
    SM_BR2  = 4'b0010,
    SM_IO   = 4'b0100,
    SM_WB   = 4'b1000
  } state_type;
endpackage

// [hw/io_map_if.sv]
// address mapping request and answer between datapath and mapper
// assumes a purely combinational mapper on the far side
`timescale 1ns/1ps
interface io_map_if;
  logic                           use_io;
  logic [bitops_pkg::IAW-1:0]     io_addr;
  logic [bitops_pkg::DAW-1:0]     data_addr;
  logic [bitops_pkg::DAW-1:0]     bus_addr;
  logic                           in_range;
  logic                           bit_ok;
  modport requester (output use_io, io_addr, data_addr,
                     input bus_addr, in_range, bit_ok);
  modport mapper    (input use_io, io_addr, data_addr,
                     output bus_addr, in_range, bit_ok);
endinterface

// [hw/io_addr_map.sv]
// maps io and data space addresses onto the internal io bus address
// assumes the io bus is addressed in data-space terms
`timescale 1ns/1ps
module io_addr_map (
  io_map_if.mapper m
);
  import bitops_pkg::*;

  // ==========================================================
  // address translation
  // io instructions land at io address plus offset
  always_comb begin
    if (m.use_io) begin
      m.bus_addr = DAW'({3'h0, m.io_addr}) + IO_DS_OFS;
      m.in_range = 1'b1;
    end else begin
      // extended region only via data-space loads and stores
      m.bus_addr = m.data_addr;
      m.in_range = (m.data_addr >= DS_IO_MIN);
    end
  end

  // single-bit access limited to the low io block
  assign m.bit_ok = m.use_io && (m.io_addr <= IO_BIT_MAX);
endmodule

// [verif/io_periph_model.sv]
// peripheral register space on the internal io bus
// assumes data-space addressing and one-cycle read and write strobes
`timescale 1ns/1ps
module io_periph_model #(
  parameter logic [8:0] W1C_ADDR = 9'h036
) (
  input  wire logic       i_core_clk,
  input  wire logic [8:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_we,
  input  wire logic       i_re,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [512];
  logic [7:0] last;
  // ==========================================================
  // storage, each cell starts at its own low address byte
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0];
    end
    last = 8'h00;
  end
  // whole byte returned while selected, inverse of last otherwise
  always_comb begin
    o_rdata = i_re ? mem[i_addr] : ~last;
  end
  // one flag register clears the bits written as one
  always @(posedge i_core_clk) begin
    if (i_re) begin
      last <= mem[i_addr];
    end
    if (i_we) begin
      mem[i_addr] <= (i_addr == W1C_ADDR) ? (mem[i_addr] & ~i_wdata) : i_wdata;
    end
  end
endmodule

// [verif/bit_ops_io_access_datapath_tb.sv]
// self-checking bench for the bit and io datapath
// assumes the io peripheral model and bitops_pkg are compiled first
`timescale 1ns/1ps
module bit_ops_io_access_datapath_tb;
  import bitops_pkg::*;
  typedef struct {
    logic [7:0]  res;
    logic [7:0]  sr;
    logic [15:0] pc;
    logic        skip;
    logic        bad;
    logic        has_res;
  } exp_type;
  logic        i_core_clk, i_nrst, i_op_valid, i_reg_wr, i_reg_rd;
  op_type      i_op_code;
  logic [7:0]  i_opnd, i_reg_wdata, i_io_rdata, o_result, o_stat, o_io_wdata, o_reg_rdata;
  logic [2:0]  i_bit_sel;
  logic [5:0]  i_io_addr;
  logic [8:0]  i_data_addr, o_io_addr;
  logic [6:0]  i_offset;
  logic [15:0] i_pc, o_pc_next, pc_m;
  logic [1:0]  i_reg_addr;
  logic        o_busy, o_done, o_result_we, o_skip, o_bad_addr, o_io_we, o_io_re;
  logic [7:0]  stat_m, res_m, rd_exp;
  logic [7:0]  mem_m [512];
  logic [31:0] seed;
  exp_type     q [$];
  logic [7:0]  rq [$];
  int          err_count, checked;
  op_type      tbl [10] = '{OP_SHL, OP_SHR, OP_RCL, OP_RCR, OP_SAR, OP_SWAP,
                            OP_FLAG_SET, OP_FLAG_CLR, OP_BIT_TO_T, OP_T_TO_BIT};
  bit_ops_io_datapath uut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_opnd(i_opnd),
    .i_bit_sel(i_bit_sel), .i_io_addr(i_io_addr), .i_data_addr(i_data_addr),
    .i_offset(i_offset), .i_pc(i_pc), .o_busy(o_busy), .o_done(o_done),
    .o_result(o_result), .o_result_we(o_result_we), .o_pc_next(o_pc_next),
    .o_skip(o_skip), .o_bad_addr(o_bad_addr), .o_stat(o_stat), .o_io_addr(o_io_addr),
    .o_io_wdata(o_io_wdata), .o_io_we(o_io_we), .o_io_re(o_io_re),
    .i_io_rdata(i_io_rdata), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
  io_periph_model peri (.i_core_clk(i_core_clk), .i_addr(o_io_addr),
    .i_wdata(o_io_wdata), .i_we(o_io_we), .i_re(o_io_re), .o_rdata(i_io_rdata));
  // ==========================================================
  // clock, checking and closing
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // drivers that also note the expected outcome
  task automatic op(input op_type c, input logic [7:0] d, input logic [2:0] b,
                    input logic [5:0] io, input logic [8:0] da, input logic [6:0] k);
    exp_type e;
    logic [7:0] r;
    logic [8:0] ba;
    logic cy;
    int n;
    e = '{res_m, stat_m, 16'h0000, 1'b0, 1'b0, 1'b0};
    e.pc = rnd();
    r = res_m;
    ba = {3'h0, io} + IO_DS_OFS;
    cy = 1'b0;
    case (c)
      OP_SHL: {cy, r} = {d, 1'b0};
      OP_SHR: {r, cy} = {1'b0, d};
      OP_RCL: {cy, r} = {d, stat_m[SB_C]};
      OP_RCR: {r, cy} = {stat_m[SB_C], d};
      OP_SAR: {r, cy} = {d[7], d};
      OP_SWAP: r = {d[3:0], d[7:4]};
      OP_FLAG_SET: e.sr[b] = 1'b1;
      OP_FLAG_CLR: e.sr[b] = 1'b0;
      OP_BIT_TO_T: e.sr[SB_T] = d[b];
      OP_T_TO_BIT: begin
        r = d;
        r[b] = stat_m[SB_T];
      end
      OP_BR_OVF_CLR, OP_BR_IRQ_ON, OP_BR_IRQ_OFF: begin
        if ((c == OP_BR_OVF_CLR && !stat_m[SB_V]) || (c == OP_BR_IRQ_ON && stat_m[SB_I])
            || (c == OP_BR_IRQ_OFF && !stat_m[SB_I])) begin
          e.pc = e.pc + {{9{k[6]}}, k};
        end
      end
      OP_IO_BIT_SET, OP_IO_BIT_CLR, OP_SKIP_ONE, OP_SKIP_ZERO: begin
        e.bad = (io > IO_BIT_MAX);
        if (!e.bad && (c == OP_SKIP_ONE || c == OP_SKIP_ZERO)) begin
          e.skip = (mem_m[ba][b] == (c == OP_SKIP_ONE));
        end else if (!e.bad) begin
          r = mem_m[ba];
          r[b] = (c == OP_IO_BIT_SET);
          mem_m[ba] = (ba == 9'h036) ? (mem_m[ba] & ~r) : r;
          r = res_m;
        end
      end
      OP_IO_IN: r = mem_m[ba];
      OP_IO_OUT: mem_m[ba] = d;
      OP_DS_LOAD, OP_DS_STORE: begin
        e.bad = (da < DS_IO_MIN);
        if (!e.bad && c == OP_DS_LOAD) r = mem_m[da];
        if (!e.bad && c == OP_DS_STORE) mem_m[da] = d;
      end
      default: r = res_m;
    endcase
    if (c inside {OP_SHL, OP_SHR, OP_RCL, OP_RCR, OP_SAR}) begin
      e.sr[SB_C] = cy;
      e.sr[SB_Z] = (r == 8'h00);
      e.sr[SB_N] = r[7];
      e.sr[SB_V] = r[7] ^ cy;
    end
    e.has_res = !e.bad && (c inside {OP_SHL, OP_SHR, OP_RCL, OP_RCR, OP_SAR, OP_SWAP,
                                     OP_T_TO_BIT, OP_IO_IN, OP_DS_LOAD});
    e.res = e.has_res ? r : res_m;
    res_m = e.res;
    stat_m = e.sr;
    e.pc = e.pc + 16'h0001;
    pc_m = e.pc;
    q.push_back(e);
    @(posedge i_core_clk);
    i_op_valid <= 1'b1;
    i_op_code <= c;
    i_opnd <= d;
    i_bit_sel <= b;
    i_io_addr <= io;
    i_data_addr <= da;
    i_offset <= k;
    i_pc <= e.pc - 16'h0001 - ((e.pc - 16'h0001 != 16'h0000) ? 16'h0000 : 16'h0000);
    if (c inside {OP_BR_OVF_CLR, OP_BR_IRQ_ON, OP_BR_IRQ_OFF} && e.skip == 1'b0) begin
      i_pc <= seed[15:0];
    end
    @(posedge i_core_clk);
    i_op_valid <= 1'b0;
    n = 0;
    @(negedge i_core_clk);
    while (o_done !== 1'b1 && n < 6) begin
      @(negedge i_core_clk);
      n++;
    end
  endtask
  task automatic reg_acc(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= wr;
    i_reg_rd <= !wr;
    if (wr && a == REG_STATUS) stat_m = d;
    if (!wr) rq.push_back(a == REG_STATUS ? stat_m : a == REG_RESULT ? res_m :
                          a == REG_PC_LO ? pc_m[7:0] : pc_m[15:8]);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
  endtask
  // ==========================================================
  // monitor compares each completion against the oldest note
  always @(negedge i_core_clk) begin
    if (o_done === 1'b1) begin
      exp_type e;
      if (q.size() > 0) e = q.pop_front();
      else e = '{8'hXX, 8'hXX, 16'hXXXX, 1'bX, 1'bX, 1'b0};
      if (e.has_res) chk(o_result, e.res);
      chk({o_result_we, o_busy}, {e.has_res, 1'b0});
      chk(o_stat, e.sr);
      chk(o_pc_next, e.pc);
      chk({o_skip, o_bad_addr}, {e.skip, e.bad});
    end
    if (rd_exp === 8'h01) chk(o_reg_rdata, rq.pop_front());
    rd_exp <= {7'h00, i_reg_rd};
  end
  // ==========================================================
  // main sequence
  initial begin
    {i_nrst, i_op_valid, i_reg_wr, i_reg_rd, i_opnd, i_bit_sel} = '0;
    {i_io_addr, i_data_addr, i_offset, i_pc, i_reg_addr, i_reg_wdata} = '0;
    {err_count, checked} = '0;
    i_op_code = OP_NOP;
    {stat_m, res_m, pc_m, rd_exp} = '0;
    seed = 32'd51;
    for (int i = 0; i < 512; i++) mem_m[i] = i[7:0];
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    reg_acc(1'b0, REG_STATUS, 8'h00);
    // every single-cycle op with random operands
    for (int i = 0; i < 40; i++) op(tbl[i % 10], rnd(), rnd(), 6'h00, 9'h000, 7'h00);
    // branches on each side of their flag, offsets 0x40, 0x3F and 0x41
    op(OP_FLAG_CLR, 8'h00, 3'd3, 6'h00, 9'h000, 7'h00);
    op(OP_BR_OVF_CLR, 8'h00, 3'd0, 6'h00, 9'h000, 7'h40);
    op(OP_FLAG_SET, 8'h00, 3'd3, 6'h00, 9'h000, 7'h00);
    op(OP_BR_OVF_CLR, 8'h00, 3'd0, 6'h00, 9'h000, 7'h3F);
    for (int i = 0; i < 2; i++) begin
      op(i ? OP_FLAG_CLR : OP_FLAG_SET, 8'h00, 3'd7, 6'h00, 9'h000, 7'h00);
      op(OP_BR_IRQ_ON, 8'h00, 3'd0, 6'h00, 9'h000, 7'h3F);
      op(OP_BR_IRQ_OFF, 8'h00, 3'd0, 6'h00, 9'h000, 7'h41);
    end
    // io bit work, a write-one-to-clear flag, the range edge and beyond
    // reserved io cells are never written here
    op(OP_IO_BIT_CLR, 8'h00, 3'd0, 6'h05, 9'h000, 7'h00);
    op(OP_IO_BIT_SET, 8'h00, 3'd7, 6'h1F, 9'h000, 7'h00);
    op(OP_IO_BIT_SET, 8'h00, 3'd0, 6'h16, 9'h000, 7'h00);
    op(OP_IO_BIT_SET, 8'h00, 3'd0, 6'h20, 9'h000, 7'h00);
    for (int a = 0; a < 3; a++) begin
      op(OP_IO_IN, 8'h00, 3'd0, a == 0 ? 6'h05 : a == 1 ? 6'h1F : 6'h16, 9'h000, 7'h00);
      op(OP_SKIP_ONE, 8'h00, 3'(a + 1), 6'h1F, 9'h000, 7'h00);
      op(OP_SKIP_ZERO, 8'h00, 3'(a + 5), 6'h1F, 9'h000, 7'h00);
    end
    op(OP_SKIP_ZERO, 8'h00, 3'd0, 6'h21, 9'h000, 7'h00);
    // io out against a data-space load of the same cell, extended cells stored and loaded, an address below range
    op(OP_IO_OUT, 8'h5A, 3'd0, 6'h3F, 9'h000, 7'h00);
    op(OP_DS_LOAD, 8'h00, 3'd0, 6'h00, 9'h05F, 7'h00);
    op(OP_DS_STORE, 8'hC3, 3'd0, 6'h00, 9'h1FF, 7'h00);
    op(OP_DS_STORE, 8'h3C, 3'd0, 6'h00, 9'h060, 7'h00);
    op(OP_DS_LOAD, 8'h00, 3'd0, 6'h00, 9'h1FF, 7'h00);
    op(OP_DS_LOAD, 8'h00, 3'd0, 6'h00, 9'h060, 7'h00);
    op(OP_DS_LOAD, 8'h00, 3'd0, 6'h00, 9'h01F, 7'h00);
    // software port: status write, ignored write, every read back
    reg_acc(1'b1, REG_STATUS, 8'hA5);
    reg_acc(1'b1, REG_RESULT, 8'h77);
    for (int a = 0; a < 4; a++) reg_acc(1'b0, 2'(a), 8'h00);
    repeat (3) @(posedge i_core_clk);
    final_report();
  end
  // watchdog against a hung handshake
  initial begin
    #100000;
    err_count++;
    final_report();
  end
endmodule
